// [verilog/eepce_pkg.sv]
package eepce_pkg;
  // bus and memory geometry
  localparam int PADDR_W   = 14;
  localparam int MEM_IDX_W = 10;
  localparam int MEM_DEPTH = 513;
  // register byte offsets
  localparam logic [13:0] CTRL_OFF = 14'h0000;
  localparam logic [13:0] CFG_OFF  = 14'h0004;
  localparam logic [13:0] DIV_OFF  = 14'h0008;
  localparam logic [13:0] NVR_OFF  = 14'h000c;
  localparam logic [13:0] STAT_OFF = 14'h0010;
  // array window: cpu byte address a sits at bus byte address 4*a
  localparam logic [2:0]  ARR_TAG      = 3'h4;
  localparam logic [9:0]  NVR_IDX      = 10'h200;
  localparam logic [9:0]  SEC_LO_IDX   = 10'h0f0;
  localparam logic [9:0]  SEC_HI_IDX   = 10'h0ff;
  localparam logic [9:0]  ARR_LAST_IDX = 10'h1ff;
  localparam logic [6:0]  BLK_LAST     = 7'h7f;
  // control register fields
  localparam int CTL_SPARE   = 7;
  localparam int CTL_PWRDN   = 6;
  localparam int CTL_MODE_HI = 5;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_LATCH   = 3;
  localparam int CTL_AUTO    = 2;
  localparam int CTL_HV      = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hfd;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  // protection config fields
  localparam int         CFG_LOCK       = 4;
  localparam logic [7:0] CFG_SPARE_MASK = 8'he0;
  localparam logic [7:0] CFG_RST        = 8'hff;
  localparam logic [7:0] NVR_FACTORY    = 8'hf0;
  localparam logic [7:0] ERASED         = 8'hff;
  // status fields
  localparam int STAT_BUSY    = 0;
  localparam int STAT_FAIL    = 1;
  localparam int STAT_REFUSED = 2;
  // operation codes from the two mode bits
  typedef enum logic [1:0] {
    MODE_PROG  = 2'b00,
    MODE_BYTE  = 2'b01,
    MODE_BLOCK = 2'b10,
    MODE_BULK  = 2'b11
  } eepce_mode_t;
  // timebase
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TIMEBASE_NS   = 35000;
  localparam logic [15:0] DIV_RST = 16'((TIMEBASE_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS);
endpackage

// [verilog/eepce_mem_if.sv]
`timescale 1ns/1ps
interface eepce_mem_if;
  logic       we;
  logic       erase;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output we, erase, addr, wdata, input rdata);
  modport mem (input we, erase, addr, wdata, output rdata);
endinterface

// [verilog/eepce_mem.sv]
`timescale 1ns/1ps
module eepce_mem #(
  parameter int DEPTH = eepce_pkg::MEM_DEPTH // array bytes plus the config byte
) (
  input  wire logic CLK_I, // clock
  eepce_mem_if.mem  port   // access port from the controller
);
  import eepce_pkg::*;

  typedef struct packed {
    logic [7:0] rdata;
  } eepce_mem_st_t;

  eepce_mem_st_t r_reg;
  eepce_mem_st_t r_next;
  // blank array, factory config byte; the write process below is the only writer
  logic [7:0]    cells [DEPTH] = '{NVR_IDX: NVR_FACTORY, default: ERASED};

  // registered read data
  always_comb begin
    r_next       = r_reg;
    r_next.rdata = cells[port.addr];
  end

  // program only clears bits, erase sets the whole byte
  always_ff @(posedge CLK_I) begin
    r_reg <= r_next;
    if (port.we) begin
      cells[port.addr] <= port.erase ? ERASED : (cells[port.addr] & port.wdata);
    end
  end

  assign port.rdata = r_reg.rdata;
endmodule // eepce_mem

// [verilog/eepce_ctrl.sv]
//
// Functional notes
// - with latch set only writes to the array or the config byte are captured
// - with latch set, control writes are refused until an array write is captured
// - each later valid array write replaces captured address and data
// - array read under latch returns captured data, loads read address
// - high voltage enable cannot be set without latch and a captured write
// - setting high voltage enable turns the pump on and starts the operation
// - auto mode: timer ends cycle and clears high voltage enable
// - clearing enable and latch together clears only the enable
// - latch stays set while high voltage enable is set
// - the two mode bits select program, byte, block or bulk erase
// - erase target: the byte, its 128-byte block, or the whole array
// - reset clears power-down, mode bits, latch and high voltage enable
// - power-down disables the array; accesses are undefined
// - four 128-byte blocks, each protect bit blocks program and erase there
// - armed security guards 8f0-8ff and refuses block and bulk erase
// - once security is armed nothing can disarm it
// - config bits 4:0 are read-only, whole register reloaded from the config byte at reset
// - control bit 7 and config bits 7:5 store only, control nothing
// - only unprotected bytes and the config byte may change
// - timing runs on a 35 us timebase from a programmable divider
// - program clears bits, erase sets them, erased reads all ones
`timescale 1ns/1ps
module eepce_ctrl #(
  parameter logic [15:0] PROG_TICKS        = 16'd100, // auto end of program, in ticks
  parameter logic [15:0] BYTE_ERASE_TICKS  = 16'd100, // auto end of byte erase
  parameter logic [15:0] BLOCK_ERASE_TICKS = 16'd100, // auto end of block erase
  parameter logic [15:0] BULK_ERASE_TICKS  = 16'd100  // auto end of bulk erase
) (
  input  wire logic                          CLK_I,       // 100 MHz bus clock
  input  wire logic                          RESETN_I,    // async reset, active low
  input  wire logic                          PSEL_I,      // apb select
  input  wire logic                          PENABLE_I,   // apb access phase
  input  wire logic                          PWRITE_I,    // apb direction
  input  wire logic [eepce_pkg::PADDR_W-1:0] PADDR_I,     // apb byte address
  input  wire logic [31:0]                   PWDATA_I,    // apb write data
  output logic      [31:0]                   PRDATA_O,    // apb read data
  output logic                               PREADY_O,    // apb ready
  output logic                               PSLVERR_O,   // unmapped address
  output logic                               PUMP_ON_O,   // charge pump enable
  output logic                               ARRAY_OFF_O  // array power down
);
  import eepce_pkg::*;

  typedef enum logic [1:0] {ST_BOOT, ST_LOAD, ST_IDLE, ST_APPLY} eepce_state_t;

  typedef struct packed {
    eepce_state_t st;
    logic [7:0]   ctrl;
    logic [7:0]   cfg;
    logic [15:0]  div;
    logic [9:0]   lat_idx;
    logic [7:0]   lat_data;
    logic         lat_valid;
    eepce_mode_t  op_mode;
    logic         op_ok;
    logic         fail;
    logic         refused;
    logic [15:0]  tb_cnt;
    logic [15:0]  tick_cnt;
    logic [9:0]   sweep;
    logic [9:0]   sweep_end;
    logic         rd_wait;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } eepce_st_t;

  // control fields cleared, config all protected until reloaded
  localparam eepce_st_t ST_RST = '{st: ST_BOOT, ctrl: CTRL_RST, cfg: CFG_RST,
                                   div: DIV_RST, op_mode: MODE_PROG, default: '0};

  eepce_st_t   r_reg;
  eepce_st_t   r_next;
  eepce_mem_if mif ();

  logic        is_ctrl;
  logic        is_cfg;
  logic        is_div;
  logic        is_stat;
  logic        is_nvr;
  logic        is_arr;
  logic        is_mem;
  logic        mapped;
  logic        access;
  logic        done;
  logic        raw_read;
  logic        serving;
  logic [9:0]  apb_idx;
  logic [31:0] rd_val;

  eepce_mem u_mem (
    .CLK_I (CLK_I),
    .port  (mif)
  );

  // may a program or erase change this byte
  function automatic logic may_change(input logic [9:0] idx, input eepce_mode_t mode,
                                      input logic [7:0] cfg);
    logic ok;
    ok = 1'b1;
    if (idx == NVR_IDX) begin
      ok = cfg[CFG_LOCK] && (mode == MODE_PROG || mode == MODE_BYTE);
    end else begin
      if (cfg[idx[8:7]]) begin
        ok = 1'b0;
      end
      if (!cfg[CFG_LOCK]) begin
        if (idx >= SEC_LO_IDX && idx <= SEC_HI_IDX) begin
          ok = 1'b0;
        end
        if (mode == MODE_BLOCK || mode == MODE_BULK) begin
          ok = 1'b0;
        end
      end
    end
    return ok;
  endfunction

  // terminal tick count of the running operation
  function automatic logic [15:0] term_of(input eepce_mode_t mode);
    case (mode)
      MODE_PROG:  return PROG_TICKS;
      MODE_BYTE:  return BYTE_ERASE_TICKS;
      MODE_BLOCK: return BLOCK_ERASE_TICKS;
      default:    return BULK_ERASE_TICKS;
    endcase
  endfunction

  // address decode
  assign is_ctrl  = PADDR_I == CTRL_OFF;
  assign is_cfg   = PADDR_I == CFG_OFF;
  assign is_div   = PADDR_I == DIV_OFF;
  assign is_stat  = PADDR_I == STAT_OFF;
  assign is_nvr   = PADDR_I == NVR_OFF;
  assign is_arr   = PADDR_I[13:11] == ARR_TAG && PADDR_I[1:0] == 2'b00;
  assign is_mem   = is_arr || is_nvr;
  assign mapped   = is_ctrl || is_cfg || is_div || is_stat || is_mem;
  assign apb_idx  = is_nvr ? NVR_IDX : {1'b0, PADDR_I[10:2]};
  assign access   = PSEL_I && PENABLE_I;
  assign done     = access && r_reg.pready;
  assign raw_read = is_mem && !PWRITE_I && !r_reg.ctrl[CTL_LATCH] && !r_reg.ctrl[CTL_PWRDN];
  assign serving  = r_reg.st == ST_IDLE || r_reg.st == ST_APPLY;

  // read value of registers and latched data
  always_comb begin
    rd_val = 32'h0;
    if (is_ctrl) begin
      rd_val = {24'h0, r_reg.ctrl & CTRL_WMASK};
    end else if (is_cfg) begin
      rd_val = {24'h0, r_reg.cfg};
    end else if (is_div) begin
      rd_val = {16'h0, r_reg.div};
    end else if (is_stat) begin
      rd_val = {29'h0, r_reg.refused, r_reg.fail,
                r_reg.st == ST_APPLY || r_reg.ctrl[CTL_HV]};
    end else if (is_mem && !r_reg.ctrl[CTL_PWRDN]) begin
      rd_val = {24'h0, r_reg.lat_data};
    end
  end

  // next state of the whole block
  always_comb begin
    logic [7:0]  nc;
    eepce_mode_t md;
    nc            = 8'h0;
    md            = MODE_PROG;
    r_next        = r_reg;
    r_next.pready = 1'b0;
    mif.we        = 1'b0;
    mif.erase     = r_reg.op_mode != MODE_PROG;
    mif.wdata     = r_reg.lat_data;
    mif.addr      = apb_idx;

    // bus answer: one wait state, two for a direct array read
    if (access && !r_reg.pready && serving) begin
      if (raw_read) begin
        if (r_reg.rd_wait) begin
          r_next.pready  = 1'b1;
          r_next.pslverr = 1'b0;
          r_next.prdata  = {24'h0, mif.rdata};
          r_next.rd_wait = 1'b0;
        end else if (r_reg.st == ST_IDLE) begin
          r_next.rd_wait = 1'b1;
        end
      end else begin
        r_next.pready  = 1'b1;
        r_next.pslverr = !mapped;
        r_next.prdata  = mapped ? rd_val : 32'h0;
      end
    end

    // effects at the completing edge
    if (done && PWRITE_I) begin
      if (is_ctrl && !(r_reg.ctrl[CTL_LATCH] && !r_reg.lat_valid)) begin
        nc = PWDATA_I[7:0] & CTRL_WMASK;
        if (nc[CTL_HV] && !r_reg.ctrl[CTL_HV] &&
            !(r_reg.ctrl[CTL_LATCH] && nc[CTL_LATCH] && r_reg.lat_valid)) begin
          nc[CTL_HV] = 1'b0;
        end
        if (r_reg.ctrl[CTL_HV] && !nc[CTL_LATCH]) begin
          nc[CTL_LATCH] = 1'b1;
        end
        r_next.ctrl = nc;
      end
      if (is_cfg) begin
        r_next.cfg = (r_reg.cfg & ~CFG_SPARE_MASK) | (PWDATA_I[7:0] & CFG_SPARE_MASK);
      end
      if (is_div && !r_reg.ctrl[CTL_LATCH]) begin
        r_next.div = PWDATA_I[15:0];
      end
      if (is_mem && r_reg.ctrl[CTL_LATCH] && !r_reg.ctrl[CTL_PWRDN] && !r_reg.ctrl[CTL_HV]) begin
        r_next.lat_idx   = apb_idx;
        r_next.lat_data  = PWDATA_I[7:0];
        r_next.lat_valid = 1'b1;
      end
    end else if (done && is_mem && r_reg.ctrl[CTL_LATCH] && !r_reg.ctrl[CTL_PWRDN]) begin
      r_next.lat_idx = apb_idx;
      if (r_reg.ctrl[CTL_HV]) begin
        r_next.fail = 1'b1;
      end
    end

    // timebase and auto termination while high voltage is on
    if (r_reg.ctrl[CTL_HV]) begin
      if (16'(r_reg.tb_cnt + 16'd1) >= r_reg.div) begin
        r_next.tb_cnt   = 16'h0;
        r_next.tick_cnt = 16'(r_reg.tick_cnt + 16'd1);
      end else begin
        r_next.tb_cnt = 16'(r_reg.tb_cnt + 16'd1);
      end
      if (r_reg.ctrl[CTL_AUTO] && r_reg.tick_cnt >= term_of(r_reg.op_mode)) begin
        r_next.ctrl[CTL_HV] = 1'b0;
      end
    end

    // start of a cycle: freeze operation and its permission
    if (r_next.ctrl[CTL_HV] && !r_reg.ctrl[CTL_HV]) begin
      md              = eepce_mode_t'({r_next.ctrl[CTL_MODE_HI], r_next.ctrl[CTL_MODE_LO]});
      r_next.op_mode  = md;
      r_next.op_ok    = (md == MODE_BULK) ? (r_reg.cfg[CFG_LOCK] && r_reg.lat_idx != NVR_IDX)
                                          : may_change(r_reg.lat_idx, md, r_reg.cfg);
      r_next.refused  = !r_next.op_ok;
      r_next.fail     = 1'b0;
      r_next.tb_cnt   = 16'h0;
      r_next.tick_cnt = 16'h0;
    end

    // end of a cycle: commit the change unless spoiled or refused
    if (r_reg.ctrl[CTL_HV] && !r_next.ctrl[CTL_HV] && r_reg.op_ok && !r_next.fail) begin
      r_next.st = ST_APPLY;
      case (r_reg.op_mode)
        MODE_BLOCK: begin
          r_next.sweep     = {r_reg.lat_idx[9:7], 7'h0};
          r_next.sweep_end = {r_reg.lat_idx[9:7], BLK_LAST};
        end
        MODE_BULK: begin
          r_next.sweep     = 10'h0;
          r_next.sweep_end = ARR_LAST_IDX;
        end
        default: begin
          r_next.sweep     = r_reg.lat_idx;
          r_next.sweep_end = r_reg.lat_idx;
        end
      endcase
    end

    if (!r_next.ctrl[CTL_LATCH]) begin
      r_next.lat_valid = 1'b0;
    end

    // sequencer
    case (r_reg.st)
      ST_BOOT: begin
        mif.addr  = NVR_IDX;
        r_next.st = ST_LOAD;
      end
      ST_LOAD: begin
        r_next.cfg = mif.rdata;
        r_next.st  = ST_IDLE;
      end
      ST_APPLY: begin
        mif.addr = r_reg.sweep;
        mif.we   = !r_reg.ctrl[CTL_PWRDN] &&
                   may_change(r_reg.sweep, r_reg.op_mode, r_reg.cfg);
        if (r_reg.sweep == r_reg.sweep_end) begin
          r_next.st = ST_IDLE;
        end else begin
          r_next.sweep = 10'(r_reg.sweep + 10'd1);
        end
      end
      default: begin
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      r_reg <= ST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign PRDATA_O    = r_reg.prdata;
  assign PREADY_O    = r_reg.pready;
  assign PSLVERR_O   = r_reg.pslverr;
  assign PUMP_ON_O   = r_reg.ctrl[CTL_HV];
  assign ARRAY_OFF_O = r_reg.ctrl[CTL_PWRDN];

  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  a_hv_needs_latch: assert property ($rose(r_reg.ctrl[CTL_HV]) |->
    $past(r_reg.ctrl[CTL_LATCH]) && $past(r_reg.lat_valid))
    else $error("high voltage set without latch or captured write");
  a_latch_held_hv: assert property (r_reg.ctrl[CTL_HV] |-> r_reg.ctrl[CTL_LATCH])
    else $error("latch cleared while high voltage on");
  a_hv_clr_keeps: assert property ($fell(r_reg.ctrl[CTL_HV]) |-> r_reg.ctrl[CTL_LATCH])
    else $error("latch fell with high voltage");
  a_ctrl_refused: assert property (done && PWRITE_I && is_ctrl && r_reg.ctrl[CTL_LATCH] &&
    !r_reg.lat_valid && !r_reg.ctrl[CTL_HV] |=> $stable(r_reg.ctrl))
    else $error("control write taken before array write");
  a_auto_end: assert property (r_reg.ctrl[CTL_HV] && r_reg.ctrl[CTL_AUTO] &&
    r_reg.tick_cnt >= term_of(r_reg.op_mode) |=> !r_reg.ctrl[CTL_HV])
    else $error("auto timer did not clear high voltage");
  a_other_no_latch: assert property (done && PWRITE_I && !is_mem |=> $stable(r_reg.lat_idx))
    else $error("non-array write changed captured address");
  a_cfg_readonly: assert property (done && PWRITE_I && is_cfg && r_reg.st == ST_IDLE |=>
    r_reg.cfg[4:0] == $past(r_reg.cfg[4:0]))
    else $error("config protection bits written by software");
  a_secure_guard: assert property (mif.we && !r_reg.cfg[CFG_LOCK] |->
    !(mif.addr >= SEC_LO_IDX && mif.addr <= SEC_HI_IDX) && mif.addr != NVR_IDX &&
    (r_reg.op_mode == MODE_PROG || r_reg.op_mode == MODE_BYTE))
    else $error("secured byte or wide erase changed");
  a_block_guard: assert property (mif.we && mif.addr != NVR_IDX |->
    !r_reg.cfg[mif.addr[8:7]])
    else $error("protected block changed");
  a_read_spoils: assert property (done && !PWRITE_I && is_mem && r_reg.ctrl[CTL_HV] &&
    !r_reg.ctrl[CTL_PWRDN] |=> r_reg.fail)
    else $error("array read under high voltage not flagged");
  a_boot_load: assert property (r_reg.st == ST_BOOT |=> r_reg.st == ST_LOAD ##1
    r_reg.st == ST_IDLE)
    else $error("config reload sequence broken");

  c_program: cover property (r_reg.st == ST_APPLY && r_reg.op_mode == MODE_PROG && mif.we);
  c_bulk: cover property (r_reg.st == ST_APPLY && r_reg.op_mode == MODE_BULK &&
    r_reg.sweep == ARR_LAST_IDX);
  c_auto: cover property ($fell(r_reg.ctrl[CTL_HV]) && r_reg.ctrl[CTL_AUTO]);
  c_refused: cover property ($rose(r_reg.refused));
endmodule // eepce_ctrl

// [dv/eepce_apb_bfm.sv]
`timescale 1ns/1ps
module eepce_apb_bfm (
  input  wire logic        clk_i,     // bus clock
  input  wire logic        pready_i,  // slave ready
  input  wire logic [31:0] prdata_i,  // slave read data
  output logic             psel_o,    // select
  output logic             penable_o, // access phase
  output logic             pwrite_o,  // direction
  output logic [13:0]      paddr_o,   // byte address
  output logic [31:0]      pwdata_o   // write data
);
  // idle bus from time zero
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 14'h0000;
    pwdata_o  = 32'h0;
  end
  // one transfer; request held until ready is sampled, then released
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule // eepce_apb_bfm

// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import eepce_pkg::*;
  logic        clk;             // bus clock
  logic        rst_n;           // reset, active low
  logic        psel;            // apb select
  logic        penable;         // apb access phase
  logic        pwrite;          // apb direction
  logic [13:0] paddr;           // apb address
  logic [31:0] pwdata;          // apb write data
  logic [31:0] prdata;          // apb read data
  logic        pready;          // apb ready
  logic        pslverr;         // apb error
  logic        pump_on;         // charge pump
  logic        array_off;       // power down
  logic [33:0] notes[$];        // check data, error, data
  logic [33:0] nt;              // oldest note
  logic [31:0] rv;              // last read value
  logic [7:0]  d1;              // random byte
  logic [7:0]  d2;              // random byte
  int          n_errors;        // mismatches
  int          samples_checked; // comparisons
  int          cycles;          // watchdog count

  eepce_ctrl #(
    .PROG_TICKS(16'd2), .BYTE_ERASE_TICKS(16'd3), .BLOCK_ERASE_TICKS(16'd4),
    .BULK_ERASE_TICKS(16'd5)
  ) eepce_ctrl_i (
    .CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PUMP_ON_O(pump_on),
    .ARRAY_OFF_O(array_off)
  );
  eepce_apb_bfm eepce_apb_bfm_i (
    .clk_i(clk), .pready_i(pready), .prdata_i(prdata), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata)
  );

  // clock, 10 ns period
  always #5 clk = ~clk;

  // bus tasks note the expected answer before issuing the transfer
  task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic e = 1'b0);
    notes.push_back({1'b0, e, 32'h0});
    eepce_apb_bfm_i.xfer(1'b1, a, d, rv);
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] x);
    notes.push_back({1'b1, 1'b0, x});
    eepce_apb_bfm_i.xfer(1'b0, a, 32'h0, rv);
  endtask
  task automatic rdq(input logic [13:0] a);
    notes.push_back(34'h0);
    eepce_apb_bfm_i.xfer(1'b0, a, 32'h0, rv);
  endtask
  function automatic logic [13:0] ba(input logic [11:0] c);
    return 14'({c, 2'b00});
  endfunction
  task automatic rst();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // latch, target, enable, poll the enable bit only, release latch
  task automatic op(input eepce_mode_t m, input logic [13:0] a, input logic [7:0] d);
    int n;
    wr(CTRL_OFF, {26'h0, m, 4'hc});
    wr(a, {24'h0, d});
    wr(CTRL_OFF, {26'h0, m, 4'hd});
    n = 0;
    do begin
      rdq(CTRL_OFF);
      n++;
    end while (rv[CTL_HV] !== 1'b0 && n < 100);
    `CHK(rv[CTL_HV], 1'b0)
    wr(CTRL_OFF, 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // answer monitor: each completed transfer consumes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        n_errors++;
        $display("[FAIL] %0t answer without request", $time);
      end else begin
        nt = notes.pop_front();
        `CHK(pslverr, nt[32])
        if (nt[33]) `CHK(prdata, nt[31:0])
      end
    end
  end
  // watchdog
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
    end
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    void'($urandom(32'hdb6f));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    rst();
    rd(CTRL_OFF, 32'h0);
    rd(CFG_OFF, 32'hf0);
    rd(DIV_OFF, {16'h0, DIV_RST});
    wr(14'h0014, 32'h0, 1'b1);
    wr(CFG_OFF, 32'h0);
    rd(CFG_OFF, 32'h10);
    wr(CTRL_OFF, 32'h80);
    rd(CTRL_OFF, 32'h80);
    wr(CTRL_OFF, 32'h0);
    wr(DIV_OFF, 32'h1);
    done("registers");
    // latched capture: refused control writes, last write wins
    wr(CTRL_OFF, 32'h0c);
    wr(DIV_OFF, 32'h5);
    wr(CTRL_OFF, 32'h0d);
    rd(CTRL_OFF, 32'h0c);
    wr(ba(12'h800), {24'h0, d1});
    wr(ba(12'h804), {24'h0, d2});
    rd(ba(12'h804), {24'h0, d2});
    wr(CTRL_OFF, 32'h0d);
    rdq(CTRL_OFF);
    while (rv[CTL_HV] !== 1'b0) rdq(CTRL_OFF);
    wr(CTRL_OFF, 32'h0);
    rd(ba(12'h804), {24'h0, d2});
    rd(ba(12'h800), 32'hff);
    done("latch");
    // manual byte erase with refused latch clears
    wr(CTRL_OFF, 32'h18);
    wr(ba(12'h804), 32'h0);
    wr(CTRL_OFF, 32'h19);
    @(negedge clk);
    `CHK(pump_on, 1'b1)
    wr(CTRL_OFF, 32'h11);
    rd(CTRL_OFF, 32'h19);
    wr(CTRL_OFF, 32'h0);
    rd(CTRL_OFF, 32'h08);
    wr(CTRL_OFF, 32'h0);
    rd(ba(12'h804), 32'hff);
    // array read under high voltage spoils the cycle, nothing is committed
    wr(CTRL_OFF, 32'h08);
    wr(ba(12'h804), 32'h0);
    wr(CTRL_OFF, 32'h09);
    rd(ba(12'h804), 32'h0);
    rd(STAT_OFF, 32'h3);
    wr(CTRL_OFF, 32'h0);
    wr(CTRL_OFF, 32'h0);
    rd(ba(12'h804), 32'hff);
    done("manual");
    // block and bulk erase reach
    op(MODE_PROG, ba(12'h800), d1);
    op(MODE_PROG, ba(12'h880), d2);
    op(MODE_BLOCK, ba(12'h8a0), 8'h0);
    rd(ba(12'h880), 32'hff);
    rd(ba(12'h800), {24'h0, d1});
    op(MODE_BULK, ba(12'h9ff), 8'h0);
    rd(ba(12'h800), 32'hff);
    done("erase");
    // power down
    wr(CTRL_OFF, 32'h40);
    @(negedge clk);
    `CHK(array_off, 1'b1)
    rd(ba(12'h800), 32'h0);
    wr(CTRL_OFF, 32'h0);
    done("power down");
    // arm security with block 0 protected, reload at reset
    op(MODE_BYTE, NVR_OFF, 8'h0);
    op(MODE_PROG, NVR_OFF, 8'he1);
    rd(NVR_OFF, 32'he1);
    rst();
    wr(DIV_OFF, 32'h1);
    rd(CFG_OFF, 32'he1);
    op(MODE_PROG, ba(12'h800), 8'h0);
    rd(STAT_OFF, 32'h4);
    rd(ba(12'h800), 32'hff);
    op(MODE_PROG, ba(12'h8f0), 8'h0);
    rd(ba(12'h8f0), 32'hff);
    op(MODE_PROG, ba(12'h900), 8'h5a);
    op(MODE_BLOCK, ba(12'h900), 8'h0);
    op(MODE_BULK, ba(12'h900), 8'h0);
    rd(ba(12'h900), 32'h5a);
    op(MODE_BYTE, NVR_OFF, 8'h0);
    rd(NVR_OFF, 32'he1);
    done("security");
    finish_test();
  end
endmodule // tb_top
